// file: rtl/gcp_pkg.sv
// command processor package: codes, payload layout, carriers
// assumes requests arrive as one header plus eight payload words
package gcp_pkg;
	localparam logic [31:0] CMD_GET_DISPLAY_INFO = 32'h0000_0100;
	localparam logic [31:0] CMD_RES_CREATE_2D    = 32'h0000_0101;
	localparam logic [31:0] CMD_RES_UNREF        = 32'h0000_0102;
	localparam logic [31:0] CMD_SET_SCANOUT      = 32'h0000_0103;
	localparam logic [31:0] CMD_RES_FLUSH        = 32'h0000_0104;
	localparam logic [31:0] CMD_XFER_TO_HOST     = 32'h0000_0105;
	localparam logic [31:0] CMD_ATTACH_BACKING   = 32'h0000_0106;
	localparam logic [31:0] CMD_DETACH_BACKING   = 32'h0000_0107;
	localparam logic [31:0] CMD_GET_CAPSET_INFO  = 32'h0000_0108;
	localparam logic [31:0] CMD_GET_CAPSET       = 32'h0000_0109;
	localparam logic [31:0] CMD_GET_EDID         = 32'h0000_010A;
	localparam logic [31:0] CMD_UPDATE_CURSOR    = 32'h0000_0300;
	localparam logic [31:0] CMD_MOVE_CURSOR      = 32'h0000_0301;
	localparam logic [31:0] RESP_OK_NODATA       = 32'h0000_1100;
	localparam logic [31:0] RESP_OK_DISPLAY_INFO = 32'h0000_1101;
	localparam logic [31:0] RESP_OK_CAPSET_INFO  = 32'h0000_1102;
	localparam logic [31:0] RESP_OK_CAPSET       = 32'h0000_1103;
	localparam logic [31:0] RESP_OK_EDID         = 32'h0000_1104;
	localparam logic [31:0] RESP_ERR_UNSPEC      = 32'h0000_1200;
	localparam logic [31:0] RESP_ERR_OUT_OF_MEM  = 32'h0000_1201;
	localparam logic [31:0] RESP_ERR_INV_SCANOUT = 32'h0000_1202;
	localparam logic [31:0] RESP_ERR_INV_RES     = 32'h0000_1203;
	localparam logic [31:0] RESP_ERR_INV_CTX     = 32'h0000_1204;
	localparam logic [31:0] RESP_ERR_INV_PARAM   = 32'h0000_1205;
	localparam logic [31:0] FLAG_FENCE           = 32'h0000_0001;
	localparam logic [31:0] FMT_B8G8R8A8 = 32'h0000_0001;
	localparam logic [31:0] FMT_B8G8R8X8 = 32'h0000_0002;
	localparam logic [31:0] FMT_A8R8G8B8 = 32'h0000_0003;
	localparam logic [31:0] FMT_X8R8G8B8 = 32'h0000_0004;
	localparam logic [31:0] FMT_R8G8B8A8 = 32'h0000_0043;
	localparam logic [31:0] FMT_X8B8G8R8 = 32'h0000_0044;
	localparam logic [31:0] FMT_A8B8G8R8 = 32'h0000_0079;
	localparam logic [31:0] FMT_R8G8B8X8 = 32'h0000_0086;
	localparam int          NUM_SCANOUTS = 16;
	localparam logic [31:0] SCANOUT_LIM  = 32'h0000_0010;
	localparam int          RES_SLOTS    = 16;
	localparam logic [31:0] EDID_BYTES   = 32'h0000_0400;
	localparam logic [4:0]  EDID_LAST    = 5'h1F;
	localparam logic [3:0]  INFO_LAST    = 4'hF;
	// payload word positions, word 0 first on the wire
	localparam int PL_RES     = 0;
	localparam int PL_CR_FMT  = 1;
	localparam int PL_CR_W    = 2;
	localparam int PL_CR_H    = 3;
	localparam int PL_AT_NR   = 1;
	localparam int PL_AT_ADDR = 2;
	localparam int PL_AT_LEN  = 4;
	localparam int PL_SO_ID   = 4;
	localparam int PL_SO_RES  = 5;
	localparam int PL_FL_RES  = 4;
	localparam int PL_TX_OFF  = 4;
	localparam int PL_TX_RES  = 6;
	localparam int PL_ED_SO   = 0;
	localparam int PL_CU_SO   = 0;
	localparam int PL_CU_X    = 1;
	localparam int PL_CU_Y    = 2;
	localparam int PL_CU_RES  = 4;
	localparam int PL_CU_HX   = 5;
	localparam int PL_CU_HY   = 6;

	typedef struct packed {
		logic [31:0] padding;
		logic [31:0] ctx_id;
		logic [63:0] fence_id;
		logic [31:0] flags;
		logic [31:0] kind;
	} gcp_hdr_t;
	// x in the lowest word; origin top left, y grows downward
	typedef struct packed {
		logic [31:0] h;
		logic [31:0] w;
		logic [31:0] y;
		logic [31:0] x;
	} gcp_rect_t;
	typedef struct packed {
		gcp_hdr_t         hdr;
		logic [7:0][31:0] pl;
	} gcp_req_t;
	typedef struct packed {
		logic             last;
		gcp_hdr_t         hdr;
		logic [7:0][31:0] pl;
	} gcp_rsp_t;
	typedef struct packed {
		logic        enabled;
		logic [31:0] flags;
		gcp_rect_t   r;
	} gcp_disp_t;
	typedef struct packed {
		logic        xfer;
		logic [15:0] so_mask;
		gcp_rect_t   r;
		logic [31:0] res_id;
		logic [63:0] offset;
		logic [63:0] bk_addr;
		logic [31:0] bk_len;
		logic [31:0] bk_cnt;
	} gcp_work_t;
	typedef struct packed {
		logic [31:0] res_id;
		logic [31:0] hot_x;
		logic [31:0] hot_y;
		logic [31:0] scanout;
		logic [31:0] x;
		logic [31:0] y;
	} gcp_cursor_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WORK = 3'b001,
		S_HDR  = 3'b010,
		S_INFO = 3'b011,
		S_EADR = 3'b100,
		S_EDAT = 3'b101
	} gcp_state_t;
endpackage : gcp_pkg

// file: rtl/gcp_buf.sv
// two-entry response buffer, output straight from storage flops
// assumes one clock, synchronous active-high reset
module gcp_buf #(
	parameter int W = 8
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_data,
	input  wire logic         i_valid,
	output logic              o_ready,
	output logic [W-1:0]      o_data,
	output logic              o_valid,
	input  wire logic         i_ready
);
	logic [1:0][W-1:0] mem_q;
	logic              wr_q;
	logic              rd_q;
	logic [1:0]        cnt_q;
	logic              push;
	logic              pop;

	assign o_ready = (cnt_q != 2'h2);
	assign o_valid = (cnt_q != 2'h0);
	assign o_data  = mem_q[rd_q];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			mem_q <= '0;
			wr_q  <= 1'b0;
		end else if (push) begin
			mem_q[wr_q] <= i_data;
			wr_q        <= ~wr_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : gcp_buf

// file: rtl/gcp_core.sv
// 2d command processor: control and cursor queues, resource table
// assumes whole requests arrive as one beat; edid data 1 cycle late
module gcp_core
	import gcp_pkg::*;
(
	input  wire logic      i_clk_sys,
	input  wire logic      i_rst,
	input  wire gcp_req_t  i_ctrl_req,
	input  wire logic      i_ctrl_valid,
	output logic           o_ctrl_ready,
	output gcp_rsp_t       o_ctrl_rsp,
	output logic           o_ctrl_rsp_valid,
	input  wire logic      i_ctrl_rsp_ready,
	input  wire gcp_req_t  i_cur_req,
	input  wire logic      i_cur_valid,
	output logic           o_cur_ready,
	output gcp_rsp_t       o_cur_rsp,
	output logic           o_cur_rsp_valid,
	input  wire logic      i_cur_rsp_ready,
	input  wire gcp_disp_t [NUM_SCANOUTS-1:0] i_disp,
	input  wire logic      i_disp_resized,
	output logic           o_display_changed,
	input  wire logic      i_edid_feature,
	output logic           o_edid_rd,
	output logic [3:0]     o_edid_scanout,
	output logic [4:0]     o_edid_beat,
	input  wire logic [7:0][31:0] i_edid_data,
	output gcp_work_t      o_work,
	output logic           o_work_valid,
	input  wire logic      i_work_done,
	output logic [15:0]    o_scan_enabled,
	output gcp_cursor_t    o_cursor
);
	gcp_state_t                     state_q;
	gcp_state_t                     follow_q;
	gcp_rsp_t                       rsp_q;
	logic [3:0]                     info_idx_q;
	logic [4:0]                     beat_q;
	logic [RES_SLOTS-1:0]           res_vld_q;
	logic [RES_SLOTS-1:0][31:0]     res_id_q;
	logic [RES_SLOTS-1:0][95:0]     res_geom_q;
	logic [RES_SLOTS-1:0][63:0]     bk_addr_q;
	logic [RES_SLOTS-1:0][31:0]     bk_len_q;
	logic [RES_SLOTS-1:0][31:0]     bk_cnt_q;
	logic [NUM_SCANOUTS-1:0][31:0]  so_res_q;
	gcp_rect_t [NUM_SCANOUTS-1:0]   so_rect_q;
	gcp_rsp_t                       buf_in;
	logic                           buf_in_valid;
	logic                           buf_in_ready;
	logic                           ctrl_acc;
	logic                           cur_acc;
	logic [31:0]                    kind;
	logic [31:0]                    sel_res;
	logic [31:0]                    sel_so;
	logic [4:0]                     hit;
	logic [4:0]                     free;
	logic [31:0]                    ex_code;
	logic                           ex_err;
	logic                           ex_work;
	logic                           fenced;
	gcp_state_t                     ex_follow;
	logic [15:0]                    fl_mask;
	logic [4:0]                     cur_hit;
	logic [31:0]                    cur_code;

	function automatic logic [4:0] find_slot(input logic [31:0] id,
		input logic [RES_SLOTS-1:0] vld,
		input logic [RES_SLOTS-1:0][31:0] ids);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < RES_SLOTS; i++)
			if (vld[i] && ids[i] == id && id != 32'h0)
				r = {1'b1, 4'(i)};
		return r;
	endfunction : find_slot

	function automatic logic fmt_ok(input logic [31:0] f);
		case (f)
		FMT_B8G8R8A8, FMT_B8G8R8X8, FMT_A8R8G8B8, FMT_X8R8G8B8,
		FMT_R8G8B8A8, FMT_X8B8G8R8, FMT_A8B8G8R8, FMT_R8G8B8X8:
			return 1'b1;
		default:
			return 1'b0;
		endcase
	endfunction : fmt_ok

	assign o_ctrl_ready = (state_q == S_IDLE);
	assign ctrl_acc     = i_ctrl_valid && o_ctrl_ready;
	assign kind         = i_ctrl_req.hdr.kind;
	assign fenced       = i_ctrl_req.hdr.flags[0];

	always_comb begin
		case (kind)
		CMD_SET_SCANOUT: sel_res = i_ctrl_req.pl[PL_SO_RES];
		CMD_RES_FLUSH:   sel_res = i_ctrl_req.pl[PL_FL_RES];
		CMD_XFER_TO_HOST: sel_res = i_ctrl_req.pl[PL_TX_RES];
		default:         sel_res = i_ctrl_req.pl[PL_RES];
		endcase
		sel_so = (kind == CMD_GET_EDID) ? i_ctrl_req.pl[PL_ED_SO]
			: i_ctrl_req.pl[PL_SO_ID];
		hit  = find_slot(sel_res, res_vld_q, res_id_q);
		free = 5'h00;
		for (int i = RES_SLOTS - 1; i >= 0; i--)
			if (!res_vld_q[i])
				free = {1'b1, 4'(i)};
		fl_mask = '0;
		for (int i = 0; i < NUM_SCANOUTS; i++)
			fl_mask[i] = (so_res_q[i] == sel_res) && hit[4];
	end

	// decode and check; first failing check names the error
	always_comb begin
		ex_code   = RESP_OK_NODATA;
		ex_work   = 1'b0;
		ex_follow = S_IDLE;
		case (kind)
		CMD_GET_DISPLAY_INFO: begin
			ex_code   = RESP_OK_DISPLAY_INFO;
			ex_follow = S_INFO;
		end
		CMD_GET_EDID: begin
			if (!i_edid_feature)
				ex_code = RESP_ERR_UNSPEC;
			else if (sel_so >= SCANOUT_LIM)
				ex_code = RESP_ERR_INV_SCANOUT;
			else begin
				ex_code   = RESP_OK_EDID;
				ex_follow = S_EADR;
			end
		end
		CMD_RES_CREATE_2D: begin
			if (sel_res == 32'h0 || hit[4])
				ex_code = RESP_ERR_INV_RES;
			else if (!fmt_ok(i_ctrl_req.pl[PL_CR_FMT]))
				ex_code = RESP_ERR_INV_PARAM;
			else if (!free[4])
				ex_code = RESP_ERR_OUT_OF_MEM;
		end
		CMD_RES_UNREF, CMD_ATTACH_BACKING, CMD_DETACH_BACKING: begin
			if (!hit[4])
				ex_code = RESP_ERR_INV_RES;
		end
		CMD_SET_SCANOUT: begin
			if (sel_so >= SCANOUT_LIM)
				ex_code = RESP_ERR_INV_SCANOUT;
			else if (sel_res != 32'h0 && !hit[4])
				ex_code = RESP_ERR_INV_RES;
		end
		CMD_RES_FLUSH: begin
			if (!hit[4])
				ex_code = RESP_ERR_INV_RES;
			else
				ex_work = 1'b1;
		end
		CMD_XFER_TO_HOST: begin
			if (!hit[4])
				ex_code = RESP_ERR_INV_RES;
			else if (bk_cnt_q[hit[3:0]] == 32'h0)
				ex_code = RESP_ERR_UNSPEC; // no backing attached
			else
				ex_work = 1'b1;
		end
		// capability sets belong to 3d mode, not offered here
		default: ex_code = RESP_ERR_UNSPEC;
		endcase
		ex_err = (ex_code[15:8] == RESP_ERR_UNSPEC[15:8]);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q    <= S_IDLE;
			follow_q   <= S_IDLE;
			rsp_q      <= '0;
			info_idx_q <= 4'h0;
			beat_q     <= 5'h00;
			o_edid_scanout <= 4'h0;
		end else begin
			case (state_q)
			S_IDLE: if (ctrl_acc) begin
				rsp_q.hdr.kind     <= ex_code;
				rsp_q.hdr.flags    <= i_ctrl_req.hdr.flags & FLAG_FENCE;
				rsp_q.hdr.fence_id <= fenced ? i_ctrl_req.hdr.fence_id
					: 64'h0;
				rsp_q.hdr.ctx_id   <= i_ctrl_req.hdr.ctx_id;
				rsp_q.hdr.padding  <= 32'h0;
				rsp_q.pl           <= '0;
				rsp_q.pl[0]        <= (ex_follow == S_EADR) ? EDID_BYTES
					: 32'h0;
				rsp_q.last         <= (ex_follow == S_IDLE);
				follow_q           <= ex_follow;
				o_edid_scanout     <= sel_so[3:0];
				info_idx_q         <= 4'h0;
				beat_q             <= 5'h00;
				// unfenced work answers at once; fenced waits for it
				state_q <= (ex_work && fenced) ? S_WORK : S_HDR;
			end
			S_WORK: if (i_work_done)
				state_q <= S_HDR;
			S_HDR: if (buf_in_ready)
				state_q <= follow_q;
			S_INFO: if (buf_in_ready) begin
				info_idx_q <= info_idx_q + 4'h1;
				if (info_idx_q == INFO_LAST)
					state_q <= S_IDLE;
			end
			S_EADR: state_q <= S_EDAT;
			S_EDAT: if (buf_in_ready) begin
				beat_q  <= beat_q + 5'h01;
				state_q <= (beat_q == EDID_LAST) ? S_IDLE : S_EADR;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	assign o_edid_rd   = (state_q == S_EADR);
	assign o_edid_beat = beat_q;

	always_comb begin
		buf_in       = rsp_q;
		buf_in_valid = 1'b0;
		case (state_q)
		S_HDR: buf_in_valid = 1'b1;
		S_INFO: begin
			buf_in_valid = 1'b1;
			buf_in       = '0;
			buf_in.pl[3:0] = i_disp[info_idx_q].r;
			buf_in.pl[4] = {31'h0, i_disp[info_idx_q].enabled};
			buf_in.pl[5] = i_disp[info_idx_q].flags;
			buf_in.last  = (info_idx_q == INFO_LAST);
		end
		S_EDAT: begin
			buf_in_valid = 1'b1;
			buf_in       = '0;
			buf_in.pl    = i_edid_data;
			buf_in.last  = (beat_q == EDID_LAST);
		end
		default: buf_in_valid = 1'b0;
		endcase
	end

	gcp_buf #(.W($bits(gcp_rsp_t))) u_rsp_buf (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_data    (buf_in),
		.i_valid   (buf_in_valid),
		.o_ready   (buf_in_ready),
		.o_data    (o_ctrl_rsp),
		.o_valid   (o_ctrl_rsp_valid),
		.i_ready   (i_ctrl_rsp_ready)
	);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			res_vld_q  <= '0;
			res_id_q   <= '0;
			res_geom_q <= '0;
			bk_addr_q  <= '0;
			bk_len_q   <= '0;
			bk_cnt_q   <= '0;
		end else if (ctrl_acc && !ex_err) begin
			case (kind)
			CMD_RES_CREATE_2D: begin
				res_vld_q[free[3:0]]  <= 1'b1;
				res_id_q[free[3:0]]   <= sel_res;
				res_geom_q[free[3:0]] <= {i_ctrl_req.pl[PL_CR_FMT],
					i_ctrl_req.pl[PL_CR_W], i_ctrl_req.pl[PL_CR_H]};
				bk_cnt_q[free[3:0]]   <= 32'h0;
			end
			CMD_RES_UNREF: begin
				res_vld_q[hit[3:0]] <= 1'b0;
				bk_cnt_q[hit[3:0]]  <= 32'h0;
			end
			CMD_ATTACH_BACKING: begin
				bk_addr_q[hit[3:0]] <= {i_ctrl_req.pl[PL_AT_ADDR + 1],
					i_ctrl_req.pl[PL_AT_ADDR]};
				bk_len_q[hit[3:0]]  <= i_ctrl_req.pl[PL_AT_LEN];
				bk_cnt_q[hit[3:0]]  <= i_ctrl_req.pl[PL_AT_NR];
			end
			CMD_DETACH_BACKING: begin
				bk_addr_q[hit[3:0]] <= 64'h0;
				bk_len_q[hit[3:0]]  <= 32'h0;
				bk_cnt_q[hit[3:0]]  <= 32'h0;
			end
			default: res_vld_q <= res_vld_q;
			endcase
		end
	end

	// overlapping or identical scanout rectangles are taken as given
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			so_res_q       <= '0;
			so_rect_q      <= '0;
			o_scan_enabled <= 16'h0000;
		end else if (ctrl_acc && !ex_err && kind == CMD_SET_SCANOUT) begin
			so_res_q[sel_so[3:0]]       <= sel_res;
			so_rect_q[sel_so[3:0]]      <= i_ctrl_req.pl[3:0];
			o_scan_enabled[sel_so[3:0]] <= (sel_res != 32'h0);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_work       <= '0;
			o_work_valid <= 1'b0;
		end else begin
			o_work_valid <= ctrl_acc && ex_work;
			if (ctrl_acc && ex_work) begin
				o_work.xfer    <= (kind == CMD_XFER_TO_HOST);
				o_work.so_mask <= (kind == CMD_RES_FLUSH) ? fl_mask
					: 16'h0000;
				o_work.r       <= i_ctrl_req.pl[3:0];
				o_work.res_id  <= sel_res;
				o_work.offset  <= {i_ctrl_req.pl[PL_TX_OFF + 1],
					i_ctrl_req.pl[PL_TX_OFF]};
				o_work.bk_addr <= bk_addr_q[hit[3:0]];
				o_work.bk_len  <= bk_len_q[hit[3:0]];
				o_work.bk_cnt  <= bk_cnt_q[hit[3:0]];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			o_display_changed <= 1'b0;
		else
			o_display_changed <= i_disp_resized;
	end

	// cursor queue has its own path so it never waits on control
	assign o_cur_ready = !o_cur_rsp_valid || i_cur_rsp_ready;
	assign cur_acc     = i_cur_valid && o_cur_ready;

	always_comb begin
		cur_hit  = find_slot(i_cur_req.pl[PL_CU_RES], res_vld_q, res_id_q);
		cur_code = RESP_OK_NODATA;
		if (i_cur_req.hdr.kind != CMD_UPDATE_CURSOR &&
			i_cur_req.hdr.kind != CMD_MOVE_CURSOR)
			cur_code = RESP_ERR_UNSPEC;
		else if (i_cur_req.pl[PL_CU_SO] >= SCANOUT_LIM)
			cur_code = RESP_ERR_INV_SCANOUT;
		else if (i_cur_req.hdr.kind == CMD_UPDATE_CURSOR && !cur_hit[4])
			cur_code = RESP_ERR_INV_RES;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_cur_rsp       <= '0;
			o_cur_rsp_valid <= 1'b0;
			o_cursor        <= '0;
		end else begin
			if (o_cur_rsp_valid && i_cur_rsp_ready)
				o_cur_rsp_valid <= 1'b0;
			if (cur_acc) begin
				o_cur_rsp_valid        <= 1'b1;
				o_cur_rsp              <= '0;
				o_cur_rsp.last         <= 1'b1;
				o_cur_rsp.hdr.kind     <= cur_code;
				o_cur_rsp.hdr.flags    <= i_cur_req.hdr.flags & FLAG_FENCE;
				o_cur_rsp.hdr.fence_id <= i_cur_req.hdr.flags[0]
					? i_cur_req.hdr.fence_id : 64'h0;
				o_cur_rsp.hdr.ctx_id   <= i_cur_req.hdr.ctx_id;
				if (cur_code == RESP_OK_NODATA) begin
					o_cursor.scanout <= i_cur_req.pl[PL_CU_SO];
					o_cursor.x       <= i_cur_req.pl[PL_CU_X];
					o_cursor.y       <= i_cur_req.pl[PL_CU_Y];
					if (i_cur_req.hdr.kind == CMD_UPDATE_CURSOR) begin
						o_cursor.res_id <= i_cur_req.pl[PL_CU_RES];
						o_cursor.hot_x  <= i_cur_req.pl[PL_CU_HX];
						o_cursor.hot_y  <= i_cur_req.pl[PL_CU_HY];
					end
				end
			end
		end
	end

	property p_fence_wait;
		@(posedge i_clk_sys) disable iff (i_rst)
		state_q == S_WORK && !i_work_done |=> state_q == S_WORK;
	endproperty
	a_fence_wait: assert property (p_fence_wait)
		else $error("fenced answer left before work done");

	property p_fence_copy;
		@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_acc && fenced |=> rsp_q.hdr.flags[0] &&
			rsp_q.hdr.fence_id == $past(i_ctrl_req.hdr.fence_id);
	endproperty
	a_fence_copy: assert property (p_fence_copy)
		else $error("fence flag or id not echoed");

	property p_early_done;
		@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_acc && ex_work && !fenced |=> state_q == S_HDR ##0 o_work_valid;
	endproperty
	a_early_done: assert property (p_early_done)
		else $error("unfenced work did not answer at once");

	property p_info_len;
		@(posedge i_clk_sys) disable iff (i_rst)
		state_q == S_INFO && info_idx_q == INFO_LAST && buf_in_ready
			|=> state_q == S_IDLE;
	endproperty
	a_info_len: assert property (p_info_len)
		else $error("display info not sixteen entries");

	property p_disable;
		@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_acc && kind == CMD_SET_SCANOUT && sel_res == 32'h0 && !ex_err
			|=> !o_scan_enabled[$past(sel_so[3:0])];
	endproperty
	a_disable: assert property (p_disable)
		else $error("scanout not disabled by resource zero");

	property p_bad_so;
		@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_acc && kind == CMD_SET_SCANOUT && sel_so >= SCANOUT_LIM
			|=> rsp_q.hdr.kind == RESP_ERR_INV_SCANOUT;
	endproperty
	a_bad_so: assert property (p_bad_so)
		else $error("bad scanout not refused");

	property p_bad_res;
		@(posedge i_clk_sys) disable iff (i_rst)
		ctrl_acc && kind == CMD_RES_FLUSH && !hit[4]
			|=> rsp_q.hdr.kind == RESP_ERR_INV_RES && !o_work_valid;
	endproperty
	a_bad_res: assert property (p_bad_res)
		else $error("unknown resource flushed");

	property p_move;
		@(posedge i_clk_sys) disable iff (i_rst)
		cur_acc && i_cur_req.hdr.kind == CMD_MOVE_CURSOR
			|=> $stable(o_cursor.res_id) && $stable(o_cursor.hot_x);
	endproperty
	a_move: assert property (p_move)
		else $error("cursor move changed image or hotspot");

	property p_cur_fast;
		@(posedge i_clk_sys) disable iff (i_rst)
		cur_acc |=> o_cur_rsp_valid;
	endproperty
	a_cur_fast: assert property (p_cur_fast)
		else $error("cursor answer delayed");
endmodule : gcp_core

// file: tb/gcp_drv_model.sv
// guest-side stand-in: sinks responses, finishes work after a delay
// assumes work requests pulse for one cycle; drives on falling edge
module gcp_drv_model #(
	parameter int DLY = 6
) (
	input  wire logic i_clk_sys,
	input  wire logic i_work_valid,
	output logic      o_work_done,
	output logic      o_rsp_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_work_done = 1'b0;
		o_rsp_ready = 1'b1;
	end
	// slow on purpose so an early fenced answer shows up
	always @(negedge i_clk_sys) begin
		if (i_work_valid === 1'b1) begin
			repeat (DLY) @(negedge i_clk_sys);
			o_work_done = 1'b1;
			@(negedge i_clk_sys);
			o_work_done = 1'b0;
		end
	end
endmodule : gcp_drv_model

// file: tb/tb_top.sv
// bench for the command processor: both queues, fencing, cursor
// assumes the guest model sinks control responses at once
module tb_top import gcp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DLY = 6;
	localparam logic [63:0] FENCE = 64'h0000_0012_0000_00AB;
	localparam logic [31:0] FMTS [8] = '{FMT_B8G8R8A8, FMT_B8G8R8X8,
		FMT_A8R8G8B8, FMT_X8R8G8B8, FMT_R8G8B8A8, FMT_X8B8G8R8,
		FMT_A8B8G8R8, FMT_R8G8B8X8};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	gcp_req_t    creq = '0;
	gcp_req_t    qreq = '0;
	logic        cval = 1'b0;
	logic        qval = 1'b0;
	gcp_rsp_t    crsp, qrsp;
	logic        crdy, qrdy, crv, qrv, crr, wv, wd;
	gcp_work_t   work, wk;
	logic [15:0] scan;
	gcp_cursor_t cur;
	gcp_hdr_t    h;
	gcp_disp_t [15:0] disp = '0;
	logic        rsz = 1'b0;
	logic        edf = 1'b0;
	logic        chg;
	logic [3:0]  esc;
	logic [4:0]  eb;
	int          n_fail = 0;
	int          n_compared = 0;
	always #25 clk = ~clk;
	gcp_core gcp_core_inst (.i_clk_sys(clk), .i_rst(rst),
		.i_ctrl_req(creq), .i_ctrl_valid(cval), .o_ctrl_ready(crdy),
		.o_ctrl_rsp(crsp), .o_ctrl_rsp_valid(crv), .i_ctrl_rsp_ready(crr),
		.i_cur_req(qreq), .i_cur_valid(qval), .o_cur_ready(qrdy),
		.o_cur_rsp(qrsp), .o_cur_rsp_valid(qrv), .i_cur_rsp_ready(1'b1),
		.i_disp(disp), .i_disp_resized(rsz), .o_display_changed(chg),
		.i_edid_feature(edf), .o_edid_rd(), .o_edid_scanout(esc),
		.o_edid_beat(eb), .i_edid_data({8{27'h0, eb}}), .o_work(work),
		.o_work_valid(wv), .i_work_done(wd), .o_scan_enabled(scan),
		.o_cursor(cur));
	gcp_drv_model #(.DLY(DLY)) gcp_drv_model_inst (.i_clk_sys(clk),
		.i_work_valid(wv), .o_work_done(wd), .o_rsp_ready(crr));
	task automatic give_verdict();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [191:0] e,
		input logic [191:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	function automatic logic [7:0][31:0] pl8(input logic [31:0] a, b, c,
		d, e, f, g);
		return {32'h0, g, f, e, d, c, b, a};
	endfunction : pl8
	task automatic ctrl(input logic [31:0] kind, input logic [31:0] fl,
		input logic [7:0][31:0] pl);
		int k;
		k = -1;
		@(negedge clk);
		creq.hdr.kind = kind;
		creq.hdr.flags = fl;
		creq.hdr.fence_id = FENCE;
		creq.pl = pl;
		cval = 1'b1;
		do @(posedge clk); while (crdy !== 1'b1);
		@(negedge clk);
		cval = 1'b0;
		for (int i = 0; i < 60 && crv !== 1'b1; i++) begin
			if (wv === 1'b1) begin
				wk = work;
				k = 0;
			end else if (k >= 0) k++;
			@(negedge clk);
		end
		h = crsp.hdr;
		if (fl[0] || k >= 0)
			chk("fence_wait", fl[0], k > DLY);
	endtask : ctrl
	task automatic cur_cmd(input logic [31:0] kind,
		input logic [7:0][31:0] pl);
		@(negedge clk);
		qreq.hdr.kind = kind;
		qreq.pl = pl;
		qval = 1'b1;
		do @(posedge clk); while (qrdy !== 1'b1);
		@(negedge clk);
		qval = 1'b0;
		for (int i = 0; i < 20 && qrv !== 1'b1; i++) @(negedge clk);
		chk("cur_rsp", RESP_OK_NODATA, qrsp.hdr.kind);
	endtask : cur_cmd
	task automatic t_create();
		// ids 1..8 at 64x64, fit for cursor images too
		for (int i = 0; i < 8; i++) begin
			ctrl(CMD_RES_CREATE_2D, 0, pl8(32'(i + 1), FMTS[i], 64, 64, 0, 0, 0));
			chk("create", RESP_OK_NODATA, h.kind);
		end
		ctrl(CMD_RES_CREATE_2D, 0, pl8(9, 5, 64, 64, 0, 0, 0));
		chk("bad_fmt", RESP_ERR_INV_PARAM, h.kind);
		ctrl(CMD_RES_CREATE_2D, 0, pl8(1, FMT_B8G8R8A8, 64, 64, 0, 0, 0));
		chk("dup_id", RESP_ERR_INV_RES, h.kind);
		ctrl(CMD_RES_UNREF, 0, pl8(8, 0, 0, 0, 0, 0, 0));
		chk("unref", RESP_OK_NODATA, h.kind);
		ctrl(CMD_RES_UNREF, 0, pl8(8, 0, 0, 0, 0, 0, 0));
		chk("unref_gone", RESP_ERR_INV_RES, h.kind);
	endtask : t_create
	task automatic t_scan();
		ctrl(CMD_SET_SCANOUT, 0, pl8(0, 0, 64, 64, 16, 1, 0));
		chk("so_range", RESP_ERR_INV_SCANOUT, h.kind);
		ctrl(CMD_SET_SCANOUT, 0, pl8(0, 0, 64, 64, 2, 1, 0));
		ctrl(CMD_SET_SCANOUT, 0, pl8(0, 0, 64, 64, 3, 1, 0));
		chk("scan_on", 16'h000C, scan);
		ctrl(CMD_RES_FLUSH, FLAG_FENCE, pl8(0, 0, 8, 8, 1, 0, 0));
		chk("fl_flag", 1'b1, h.flags[0]);
		chk("fl_fence", FENCE, h.fence_id);
		chk("fl_mask", {1'b0, 16'h000C}, {wk.xfer, wk.so_mask});
		ctrl(CMD_SET_SCANOUT, 0, pl8(0, 0, 0, 0, 2, 0, 0));
		chk("so_off", 16'h0008, scan);
	endtask : t_scan
	task automatic t_info();
		logic [191:0] e;
		for (int i = 0; i < 16; i++)
			disp[i] = {i[0], 32'(i), 32'h300, 32'h400, 32'h0, 32'(i)};
		ctrl(CMD_RES_FLUSH, 0, pl8(0, 0, 8, 8, 1, 0, 0));
		chk("fl_early", RESP_OK_NODATA, h.kind);
		ctrl(CMD_RES_FLUSH, 0, pl8(0, 0, 8, 8, 8, 0, 0));
		chk("fl_unknown", RESP_ERR_INV_RES, h.kind);
		ctrl(CMD_GET_DISPLAY_INFO, 0, '0);
		chk("info_kind", RESP_OK_DISPLAY_INFO, h.kind);
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			e = {32'(i), 31'h0, i[0], 32'h300, 32'h400, 32'h0, 32'(i)};
			chk("info_pl", e, crsp.pl[5:0]);
			chk("info_last", {1'b1, 1'(i == 15)}, {crv, crsp.last});
		end
		ctrl(CMD_GET_EDID, 0, pl8(5, 0, 0, 0, 0, 0, 0));
		chk("edid_off", RESP_ERR_UNSPEC, h.kind);
		edf = 1'b1;
		ctrl(CMD_GET_EDID, 0, pl8(5, 0, 0, 0, 0, 0, 0));
		e = {RESP_OK_EDID, EDID_BYTES};
		chk("edid_hdr", e, {h.kind, crsp.pl[0]});
		for (int i = 0; i < 32; i++) begin
			do @(negedge clk); while (crv !== 1'b1);
			e = {4'h5, 1'(i == 31), 32'(i)};
			chk("edid_beat", e, {esc, crsp.last, crsp.pl[7]});
		end
		@(negedge clk);
		rsz = 1'b1;
		@(negedge clk);
		rsz = 1'b0;
		chk("resized", 1'b1, chg);
		@(negedge clk);
		chk("resize_off", 1'b0, chg);
	endtask : t_info
	task automatic t_xfer();
		ctrl(CMD_XFER_TO_HOST, 0, pl8(0, 0, 8, 8, 32'h40, 0, 1));
		chk("no_back", RESP_ERR_UNSPEC, h.kind);
		ctrl(CMD_ATTACH_BACKING, 0, pl8(1, 1, 32'h8000, 32'h2, 32'h1000, 0, 0));
		chk("attach", RESP_OK_NODATA, h.kind);
		ctrl(CMD_XFER_TO_HOST, FLAG_FENCE, pl8(0, 0, 8, 8, 32'h40, 0, 1));
		chk("xf_kind", RESP_OK_NODATA, h.kind);
		chk("xf_off", {1'b1, 64'h40}, {wk.xfer, wk.offset});
		chk("xf_addr", 64'h2_0000_8000, wk.bk_addr);
		ctrl(CMD_DETACH_BACKING, 0, pl8(1, 0, 0, 0, 0, 0, 0));
		ctrl(CMD_XFER_TO_HOST, 0, pl8(0, 0, 8, 8, 32'h40, 0, 1));
		chk("detached", RESP_ERR_UNSPEC, h.kind);
	endtask : t_xfer
	task automatic t_cursor();
		// resource 1 already created and filled under fence, its backing since detached
		fork
			ctrl(CMD_RES_FLUSH, FLAG_FENCE, pl8(0, 0, 8, 8, 1, 0, 0));
			begin
				cur_cmd(CMD_UPDATE_CURSOR, pl8(3, 10, 20, 0, 1, 5, 6));
				chk("cur_fast", 1'b0, crdy);
			end
		join
		chk("cur_upd", {32'h1, 32'h5, 32'h6, 32'h3, 32'hA, 32'h14}, cur);
		cur_cmd(CMD_MOVE_CURSOR, pl8(4, 30, 40, 0, 7, 9, 9));
		chk("cur_mov", {32'h1, 32'h5, 32'h6, 32'h4, 32'h1E, 32'h28}, cur);
	endtask : t_cursor
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_create();
		t_scan();
		t_info();
		t_xfer();
		t_cursor();
		give_verdict();
	end
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule : tb_top
